// ==== core/bhsc_defs.vh ====
// Purpose: Constants for the buck high-performance and start-up configuration block
// Assumes: 20 MHz clk_i, byte-wide registers on a two-wire serial target
// Notes:   Offsets are register addresses as seen by the host
`ifndef BHSC_DEFS_VH
`define BHSC_DEFS_VH

`define BHSC_CLK_PERIOD_NS      50
`define BHSC_HPM_OFFSET         8'h43
`define BHSC_SUC_OFFSET         8'h4F
`define BHSC_HPM_RESET          8'hFD
`define BHSC_SUC_RESET          8'h1C
`define BHSC_READ_UNMAPPED      8'h00
`define BHSC_TARGET_ADDR        7'h5B

// High-performance setting fields
`define BHSC_HPM_EN_BIT         7
`define BHSC_HPM_MODE_BIT       6
`define BHSC_HPM_VSET_MSB       5
`define BHSC_HPM_VSET_LSB       0

// Start-up configuration fields
`define BHSC_SUC_RATE_MSB       7
`define BHSC_SUC_RATE_LSB       6
`define BHSC_SUC_STEP_MSB       5
`define BHSC_SUC_STEP_LSB       4
`define BHSC_SUC_PART_BIT       3
`define BHSC_SUC_DLY_MSB        2
`define BHSC_SUC_DLY_LSB        0

// Turn-on delay: one delay code step, and its length in clock cycles
`define BHSC_DELAY_STEP_NS      1000000
`define BHSC_DELAY_STEP_CYC     (`BHSC_DELAY_STEP_NS / `BHSC_CLK_PERIOD_NS)

`endif

// ==== core/bhsc_start.v ====
// Purpose: Turn-on timing of the channel within the power-up sequence
// Assumes: Sequencer signals come from logic on clk_i
// Notes:   Delay counts whole step units from the step-done pulse
`timescale 1ns/1ns
module bhsc_start #(
    parameter DLY_STEP_CYC = 20000
) (
    input  wire       clk_i,
    input  wire       rstn_i,
    input  wire       seq_restart_i,
    input  wire       step_done_i,
    input  wire [1:0] seq_step_i,
    input  wire [1:0] power_up_step_i,
    input  wire       step_participate_i,
    input  wire [2:0] delay_code_i,
    output reg        soft_start_begin_o,
    output reg        channel_started_o
);

    reg        waiting_r;
    reg [2:0]  units_r;
    reg [31:0] unit_cnt_r;

    wire my_step = step_done_i && step_participate_i &&
                   (seq_step_i == power_up_step_i);

    always @(posedge clk_i)
    begin
        if (!rstn_i || seq_restart_i)
        begin
            waiting_r          <= 1'b0;
            units_r            <= 3'h0;
            unit_cnt_r         <= 32'h0;
            soft_start_begin_o <= 1'b0;
            channel_started_o  <= 1'b0;
        end
        else
        begin
            soft_start_begin_o <= 1'b0;
            if (my_step && !channel_started_o && !waiting_r)
            begin
                waiting_r  <= 1'b1;
                units_r    <= delay_code_i;
                unit_cnt_r <= 32'h0;
            end
            else if (waiting_r)
            begin
                if (units_r == 3'h0)
                begin
                    waiting_r          <= 1'b0;
                    soft_start_begin_o <= 1'b1;
                    channel_started_o  <= 1'b1;
                end
                else if (unit_cnt_r == DLY_STEP_CYC - 1)
                begin
                    unit_cnt_r <= 32'h0;
                    units_r    <= units_r - 3'h1;
                end
                else
                begin
                    unit_cnt_r <= unit_cnt_r + 32'h1;
                end
            end
        end
    end

endmodule

// ==== core/bhsc_top.v ====
// Purpose: Buck channel high-performance and start-up configuration registers
// Assumes: Host uses a two-wire serial bus; SCL and SDA are asynchronous pins
// Notes:   One register pointer byte, then data; pointer auto-increments
`timescale 1ns/1ns
`include "bhsc_defs.vh"
module bhsc_top #(
    parameter DLY_STEP_CYC = `BHSC_DELAY_STEP_CYC
) (
    input  wire       clk_i,
    input  wire       rstn_i,
    input  wire       scl_i,
    input  wire       sda_i,
    output wire       sda_o,
    output reg        sda_oe_o,
    input  wire       hp_state_i,
    input  wire       seq_restart_i,
    input  wire       step_done_i,
    input  wire [1:0] seq_step_i,
    output wire       regulator_on_o,
    output reg        forced_fixed_switching_o,
    output reg        automatic_pulse_freq_o,
    output reg  [5:0] voltage_code_o,
    output reg  [1:0] ramp_rate_sel_o,
    output wire       soft_start_begin_o
);

    localparam ST_IDLE  = 4'h0;
    localparam ST_ADDR  = 4'h1;
    localparam ST_AACK  = 4'h2;
    localparam ST_REG   = 4'h3;
    localparam ST_RACK  = 4'h4;
    localparam ST_WDATA = 4'h5;
    localparam ST_WACK  = 4'h6;
    localparam ST_RDATA = 4'h7;
    localparam ST_HACK  = 4'h8;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    reg [1:0] scl_sync_r;
    reg [1:0] sda_sync_r;
    reg       scl_prev_r;
    reg       sda_prev_r;

    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end
        else
        begin
            scl_sync_r <= {scl_sync_r[0], scl_i};
            sda_sync_r <= {sda_sync_r[0], sda_i};
            scl_prev_r <= scl_sync_r[1];
            sda_prev_r <= sda_sync_r[1];
        end
    end

    wire scl_s    = scl_sync_r[1];
    wire sda_s    = sda_sync_r[1];
    wire scl_rise = scl_s && !scl_prev_r;
    wire scl_fall = !scl_s && scl_prev_r;
    wire start_c  = scl_s && scl_prev_r && !sda_s && sda_prev_r;
    wire stop_c   = scl_s && scl_prev_r && sda_s && !sda_prev_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    reg [7:0] hpm_r;
    reg [7:0] suc_r;

    function [7:0] rd_mux;
        input [7:0] ptr;
        input [7:0] hpm;
        input [7:0] suc;
        begin
            if (ptr == `BHSC_HPM_OFFSET)
                rd_mux = hpm;
            else if (ptr == `BHSC_SUC_OFFSET)
                rd_mux = suc;
            else
                rd_mux = `BHSC_READ_UNMAPPED;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Serial target

    reg [3:0] state_r;
    reg [3:0] bit_cnt_r;
    reg [7:0] shift_r;
    reg [7:0] tx_r;
    reg [7:0] ptr_r;
    reg       rnw_r;
    reg       nack_r;

    // Read data at the pointer and at the next one. Bit 7 goes out at the ACK-slot fall.
    wire [7:0] rd_cur  = rd_mux(ptr_r, hpm_r, suc_r);
    wire [7:0] rd_next = rd_mux(ptr_r + 8'h01, hpm_r, suc_r);

    // Open-drain: only ever pull low
    assign sda_o = 1'b0;

    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            state_r   <= ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r   <= 8'h00;
            tx_r      <= 8'h00;
            ptr_r     <= 8'h00;
            rnw_r     <= 1'b0;
            nack_r    <= 1'b0;
            sda_oe_o  <= 1'b0;
            hpm_r     <= `BHSC_HPM_RESET;
            suc_r     <= `BHSC_SUC_RESET;
        end
        else if (start_c)
        begin
            state_r   <= ST_ADDR;
            bit_cnt_r <= 4'h0;
            sda_oe_o  <= 1'b0;
        end
        else if (stop_c)
        begin
            state_r  <= ST_IDLE;
            sda_oe_o <= 1'b0;
        end
        else if (scl_rise)
        begin
            if (state_r == ST_ADDR || state_r == ST_REG || state_r == ST_WDATA)
            begin
                shift_r   <= {shift_r[6:0], sda_s};
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            else if (state_r == ST_RDATA)
                bit_cnt_r <= bit_cnt_r + 4'h1;
            else if (state_r == ST_HACK)
                nack_r <= sda_s;
        end
        else if (scl_fall)
        begin
            case (state_r)
                ST_ADDR:
                    if (bit_cnt_r == 4'h8)
                    begin
                        if (shift_r[7:1] == `BHSC_TARGET_ADDR)
                        begin
                            rnw_r    <= shift_r[0];
                            sda_oe_o <= 1'b1;
                            state_r  <= ST_AACK;
                        end
                        else
                            state_r <= ST_IDLE;
                    end
                ST_AACK:
                begin
                    bit_cnt_r <= 4'h0;
                    if (rnw_r)
                    begin
                        tx_r     <= {rd_cur[6:0], 1'b0};
                        sda_oe_o <= !rd_cur[7];
                        state_r  <= ST_RDATA;
                    end
                    else
                    begin
                        sda_oe_o <= 1'b0;
                        state_r  <= ST_REG;
                    end
                end
                ST_REG:
                    if (bit_cnt_r == 4'h8)
                    begin
                        ptr_r    <= shift_r;
                        sda_oe_o <= 1'b1;
                        state_r  <= ST_RACK;
                    end
                ST_RACK, ST_WACK:
                begin
                    if (state_r == ST_WACK)
                        ptr_r <= ptr_r + 8'h01;
                    sda_oe_o  <= 1'b0;
                    bit_cnt_r <= 4'h0;
                    state_r   <= ST_WDATA;
                end
                ST_WDATA:
                    if (bit_cnt_r == 4'h8)
                    begin
                        if (ptr_r == `BHSC_HPM_OFFSET)
                            hpm_r <= shift_r;
                        if (ptr_r == `BHSC_SUC_OFFSET)
                            suc_r <= shift_r;
                        sda_oe_o <= 1'b1;
                        state_r  <= ST_WACK;
                    end
                ST_RDATA:
                    if (bit_cnt_r == 4'h8)
                    begin
                        sda_oe_o <= 1'b0;
                        state_r  <= ST_HACK;
                    end
                    else
                    begin
                        sda_oe_o <= !tx_r[7];
                        tx_r     <= {tx_r[6:0], 1'b0};
                    end
                ST_HACK:
                    // A host NACK ends the read; wait for stop or repeated start
                    if (nack_r)
                        state_r <= ST_IDLE;
                    else
                    begin
                        ptr_r     <= ptr_r + 8'h01;
                        tx_r      <= {rd_next[6:0], 1'b0};
                        sda_oe_o  <= !rd_next[7];
                        bit_cnt_r <= 4'h0;
                        state_r   <= ST_RDATA;
                    end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Regulator controls

    wire channel_started;

    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            forced_fixed_switching_o <= 1'b1;
            automatic_pulse_freq_o   <= 1'b0;
            voltage_code_o           <= 6'h3D;
            ramp_rate_sel_o          <= 2'h0;
        end
        else
        begin
            forced_fixed_switching_o <= hpm_r[`BHSC_HPM_MODE_BIT];
            automatic_pulse_freq_o   <= !hpm_r[`BHSC_HPM_MODE_BIT];
            voltage_code_o           <= hpm_r[`BHSC_HPM_VSET_MSB:`BHSC_HPM_VSET_LSB];
            ramp_rate_sel_o          <= suc_r[`BHSC_SUC_RATE_MSB:`BHSC_SUC_RATE_LSB];
        end
    end

    // A channel left out of the sequence is switched on by its enable and the high-performance state alone
    assign regulator_on_o = hp_state_i && hpm_r[`BHSC_HPM_EN_BIT] &&
                            (channel_started || !suc_r[`BHSC_SUC_PART_BIT]);

    bhsc_start #(
        .DLY_STEP_CYC (DLY_STEP_CYC)
    ) u_start (
        .clk_i              (clk_i),
        .rstn_i             (rstn_i),
        .seq_restart_i      (seq_restart_i),
        .step_done_i        (step_done_i),
        .seq_step_i         (seq_step_i),
        .power_up_step_i    (suc_r[`BHSC_SUC_STEP_MSB:`BHSC_SUC_STEP_LSB]),
        .step_participate_i (suc_r[`BHSC_SUC_PART_BIT]),
        .delay_code_i       (suc_r[`BHSC_SUC_DLY_MSB:`BHSC_SUC_DLY_LSB]),
        .soft_start_begin_o (soft_start_begin_o),
        .channel_started_o  (channel_started)
    );

endmodule

// ==== tb/bhsc_props.sv ====
// Purpose: Port-level checks of the buck configuration block
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound into every bhsc_top instance
`timescale 1ns/1ns
module bhsc_props #(
    parameter DLY_STEP_CYC = 20000
) (
    input wire       clk_i,
    input wire       rstn_i,
    input wire       scl_i,
    input wire       sda_o,
    input wire       sda_oe_o,
    input wire       hp_state_i,
    input wire       step_done_i,
    input wire       regulator_on_o,
    input wire       forced_fixed_switching_o,
    input wire       automatic_pulse_freq_o,
    input wire [5:0] voltage_code_o,
    input wire [1:0] ramp_rate_sel_o,
    input wire       soft_start_begin_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    ////////////////////////////////////////////////////////////////
    // Saturates so a long idle stretch cannot wrap into a false pass
    reg [19:0] since_r;
    always @(posedge clk_i)
    begin
        if (!rstn_i || step_done_i)
            since_r <= 20'h00000;
        else if (since_r != 20'hFFFFF)
            since_r <= since_r + 20'h00001;
    end
    sequence s_pulse;
        soft_start_begin_o ##1 !soft_start_begin_o;
    endsequence
    ////////////////////////////////////////////////////////////////
    chk_mode_excl: assert property (forced_fixed_switching_o != automatic_pulse_freq_o)
        else $error("switching mode outputs agree");
    chk_hp_gate: assert property (!hp_state_i |-> !regulator_on_o)
        else $error("regulator on outside high-performance state");
    chk_start_pulse: assert property (soft_start_begin_o |-> s_pulse)
        else $error("soft start longer than one cycle");
    chk_start_cause: assert property (soft_start_begin_o |-> since_r <= 7 * DLY_STEP_CYC + 2)
        else $error("soft start without recent step completion");
    chk_reset_vals: assert property ($rose(rstn_i) |-> voltage_code_o == 6'h3D
        && ramp_rate_sel_o == 2'h0 && forced_fixed_switching_o && !sda_oe_o)
        else $error("outputs differ from power-on values");
    chk_sda_low: assert property (sda_o == 1'b0)
        else $error("data value not low");
    chk_ack_edge: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data pin changed while clock high");
    chk_field_edge: assert property ($changed({voltage_code_o, ramp_rate_sel_o,
        forced_fixed_switching_o}) |-> !scl_i)
        else $error("field output changed while clock high");
endmodule
bind bhsc_top bhsc_props #(.DLY_STEP_CYC(DLY_STEP_CYC)) u_props (
    .clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .hp_state_i(hp_state_i), .step_done_i(step_done_i),
    .regulator_on_o(regulator_on_o), .voltage_code_o(voltage_code_o),
    .forced_fixed_switching_o(forced_fixed_switching_o),
    .automatic_pulse_freq_o(automatic_pulse_freq_o),
    .ramp_rate_sel_o(ramp_rate_sel_o), .soft_start_begin_o(soft_start_begin_o)
);

// ==== tb/bhsc_host.sv ====
// Purpose: Serial bus host driving the configuration block
// Assumes: Pulled-up data line, 8 clock low and high phases
// Notes:   Releases data by driving 1; level comes from sda_i
`timescale 1ns/1ns
`include "bhsc_defs.vh"
module bhsc_host (
    input  wire clk_i,
    input  wire sda_i,
    output reg  scl_o,
    output reg  sda_o
);
    initial scl_o = 1'b1;
    initial sda_o = 1'b1;
    task tick(input integer n);
        repeat (n) @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////////
    // Data moves only with clock low, well clear of the device lag
    task bitx(input logic b, output logic r);
        sda_o <= b;
        tick(6);
        scl_o <= 1'b1;
        tick(8);
        r = sda_i;
        scl_o <= 1'b0;
        tick(2);
    endtask
    task start;
        sda_o <= 1'b1;
        tick(4);
        scl_o <= 1'b1;
        tick(8);
        sda_o <= 1'b0;
        tick(8);
        scl_o <= 1'b0;
        tick(2);
    endtask
    task stop;
        sda_o <= 1'b0;
        tick(4);
        scl_o <= 1'b1;
        tick(8);
        sda_o <= 1'b1;
        tick(8);
    endtask
    task xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bitx(d[i], r);
            q[i] = r;
        end
        bitx(m, r);
        a = !r;
    endtask
    ////////////////////////////////////////////////////////////////
    task wr(input logic [6:0] ad, input logic [7:0] p, input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic       a;
        logic       b;
        logic       c;
        start;
        xfer({ad, 1'b0}, 1'b1, q, a);
        xfer(p, 1'b1, q, b);
        xfer(d, 1'b1, q, c);
        stop;
        ok = a & b & c;
    endtask
    task rd(input logic [7:0] p, output logic [7:0] q);
        logic a;
        start;
        xfer({`BHSC_TARGET_ADDR, 1'b0}, 1'b1, q, a);
        xfer(p, 1'b1, q, a);
        start;
        xfer({`BHSC_TARGET_ADDR, 1'b1}, 1'b1, q, a);
        xfer(8'hFF, 1'b1, q, a);
        stop;
    endtask
endmodule

// ==== tb/bhsc_top_test.sv ====
// Purpose: Self-checking bench for the buck configuration block
// Assumes: 20 MHz clock, short delay step for simulation
// Notes:   Registers reached only through the serial host
`timescale 1ns/1ns
`include "bhsc_defs.vh"
module bhsc_top_test;
    localparam DLY = 4;
    reg        clk_i = 1'b0;
    reg        rstn_i = 1'b0;
    reg        hp_r = 1'b1;
    reg        rs_r = 1'b0;
    reg        done_r = 1'b0;
    reg  [1:0] step_r = 2'h0;
    wire       scl_w;
    wire       hsda_w;
    wire       sdo_w;
    wire       oe_w;
    wire       on_w;
    wire       ffs_w;
    wire       apf_w;
    wire       ss_w;
    wire [5:0] code_w;
    wire [1:0] rate_w;
    wire       sda_w = hsda_w & (oe_w ? sdo_w : 1'b1);
    integer    fail_count = 0;
    integer    cmp_count = 0;
    integer    cyc = 0;
    integer    n;
    reg  [7:0] q;
    reg        ok;
    always #25 clk_i = ~clk_i;
    bhsc_host host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl_w), .sda_o(hsda_w));
    bhsc_top #(.DLY_STEP_CYC(DLY)) dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl_w), .sda_i(sda_w),
        .sda_o(sdo_w), .sda_oe_o(oe_w), .hp_state_i(hp_r),
        .seq_restart_i(rs_r), .step_done_i(done_r), .seq_step_i(step_r),
        .regulator_on_o(on_w), .forced_fixed_switching_o(ffs_w),
        .automatic_pulse_freq_o(apf_w), .voltage_code_o(code_w),
        .ramp_rate_sel_o(rate_w), .soft_start_begin_o(ss_w)
    );
    ////////////////////////////////////////////////////////////////
    task final_report;
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Bound on the whole run; the tests need roughly 7500 cycles
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            fail_count = fail_count + 1;
            final_report;
        end
    end
    task chk(input [7:0] got, input [7:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task do_reset;
        rstn_i <= 1'b0;
        repeat (16) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask
    task w(input [7:0] p, input [7:0] d);
        host.wr(`BHSC_TARGET_ADDR, p, d, ok);
        chk({7'h00, ok}, 8'h01);
    endtask
    task rc(input [7:0] p, input [7:0] e);
        host.rd(p, q);
        chk(q, e);
    endtask
    task pulse(input [1:0] s);
        @(posedge clk_i);
        done_r <= 1'b1;
        step_r <= s;
        @(posedge clk_i);
        done_r <= 1'b0;
    endtask
    task wss(output integer c);
        c = 0;
        while (ss_w !== 1'b1 && c < 40)
        begin
            @(posedge clk_i);
            c = c + 1;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        do_reset;
        chk({code_w, rate_w}, {6'h3D, 2'h0});
        chk({5'h00, ffs_w, apf_w, on_w}, 8'h04);
        rc(8'h43, 8'hFD);
        rc(8'h4F, 8'h1C);
        $display("test reset values done");
        w(8'h43, 8'h8A);
        w(8'h4F, 8'h6B);
        chk({code_w, rate_w}, {6'h0A, 2'h1});
        chk({6'h00, ffs_w, apf_w}, 8'h01);
        rc(8'h43, 8'h8A);
        rc(8'h4F, 8'h6B);
        $display("test field writes done");
        pulse(2'h1);
        wss(n);
        chk(n[7:0], 8'h28);
        pulse(2'h2);
        chk({7'h00, on_w}, 8'h00);
        wss(n);
        chk({7'h00, n >= 3 * DLY + 1 && n <= 3 * DLY + 3}, 8'h01);
        repeat (2) @(posedge clk_i);
        chk({7'h00, on_w}, 8'h01);
        $display("test sequenced start done");
        rs_r <= 1'b1;
        @(posedge clk_i);
        rs_r <= 1'b0;
        w(8'h4F, 8'hE3);
        chk({5'h00, rate_w, on_w}, 8'h07);
        pulse(2'h2);
        wss(n);
        chk(n[7:0], 8'h28);
        hp_r <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk({7'h00, on_w}, 8'h00);
        hp_r <= 1'b1;
        w(8'h43, 8'h40);
        chk({5'h00, ffs_w, apf_w, on_w}, 8'h04);
        $display("test enable and mode done");
        w(8'h50, 8'h55);
        rc(8'h50, `BHSC_READ_UNMAPPED);
        host.wr(7'h2A, 8'h43, 8'h8A, ok);
        chk({7'h00, ok}, 8'h00);
        rc(8'h43, 8'h40);
        $display("test refused access done");
        do_reset;
        chk({code_w, rate_w}, {6'h3D, 2'h0});
        rc(8'h4F, 8'h1C);
        $display("test second reset done");
        final_report;
    end
endmodule
